/* shared/link_fc_defs.svh */
`ifndef LINK_FC_DEFS_SVH
`define LINK_FC_DEFS_SVH

// Interface geometry
`define IF_BYTES 4
`define DATA_W 32
`define KEEP_W 4
`define KEEP_ALL 4'hF

// User message size code and byte counts
`define SIZE_W 3
`define UFC_BYTES_W 5
`define UFC_BEATS_W 3

// Pause codes
`define CODE_W 4
`define CODE_RESUME 4'h0
`define CODE_MAX_COUNT 4'h8
`define CODE_HALT 4'hF
`define PAUSE_W 9

// Receive buffer
`define BUF_DEPTH 2
`define BUF_CNT_W 2

`endif

/* shared/link_fc_pkg.sv */
package link_fc_pkg;
  `include "link_fc_defs.svh"

  typedef enum logic [3:0] {
    TX_DATA  = 4'b0001,
    TX_UFC   = 4'b0010,
    TX_NFC   = 4'b0100,
    TX_PAUSE = 4'b1000
  } tx_state_t;

  typedef enum logic [2:0] {
    KIND_IDLE     = 3'h0,
    KIND_DATA     = 3'h1,
    KIND_UFC_HDR  = 3'h2,
    KIND_UFC_DATA = 3'h3,
    KIND_NFC      = 3'h4
  } beat_kind_t;

  typedef struct packed {
    beat_kind_t kind;
    logic last;
    logic [`DATA_W-1:0] data;
  } lane_word_t;

  typedef struct packed {
    logic last;
    logic [`KEEP_W-1:0] keep;
    logic [`DATA_W-1:0] data;
  } ufc_word_t;

  typedef struct packed {
    tx_state_t tx_state;
    logic [`UFC_BEATS_W-1:0] ufc_beats_left;
    logic in_frame;
    logic [`PAUSE_W-1:0] pause_left;
    logic halt;
    logic [`CODE_W-1:0] nfc_send_code;
    lane_word_t lane;
    logic nfc_rx_valid;
    logic [`CODE_W-1:0] nfc_rx_code;
    logic [`UFC_BYTES_W-1:0] rx_bytes_left;
    ufc_word_t [`BUF_DEPTH-1:0] buf_mem;
    logic buf_wr;
    logic buf_rd;
    logic [`BUF_CNT_W-1:0] buf_count;
  } fc_state_t;
endpackage

/* verilog/link_flow_control_msg_port.sv */
`timescale 1ns/1ns
`include "link_fc_defs.svh"
module link_flow_control_msg_port
  import link_fc_pkg::*;
#(
  parameter bit NFC_ENABLE = 1'b1,
  parameter bit FULL_DUPLEX = 1'b1,
  parameter bit BIG_ENDIAN = 1'b0,
  parameter bit NFC_IMMEDIATE = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Regular transmit stream from the user
  input wire logic [`DATA_W-1:0] tx_tdata,
  input wire logic tx_tvalid,
  input wire logic tx_tlast,
  output logic tx_tready,
  // User message transmit request
  input wire logic [`SIZE_W-1:0] ufc_tx_tdata,
  input wire logic ufc_tx_tvalid,
  output logic ufc_tx_tready,
  // Idle request transmit
  input wire logic [`CODE_W-1:0] nfc_tx_tdata,
  input wire logic nfc_tx_tvalid,
  output logic nfc_tx_tready,
  // Idle request received from the partner
  output logic [`CODE_W-1:0] nfc_rx_tdata,
  output logic nfc_rx_tvalid,
  // User message receive stream
  output logic [`DATA_W-1:0] ufc_rx_tdata,
  output logic [`KEEP_W-1:0] ufc_rx_tkeep,
  output logic ufc_rx_tlast,
  output logic ufc_rx_tvalid,
  input wire logic ufc_rx_tready,
  // Beats toward the lane logic
  output lane_word_t lane_tx,
  // Beats from the lane logic
  input wire lane_word_t lane_rx,
  input wire logic lane_rx_valid,
  output logic lane_rx_ready
);

  localparam bit NFC_ON = NFC_ENABLE && FULL_DUPLEX;

  fc_state_t cur;
  fc_state_t next_cur;

  logic pause_pending;
  logic pause_go;
  logic nfc_accept;
  logic ufc_accept;
  logic data_accept;
  logic rx_take;
  logic rx_pop;
  logic [`CODE_W-1:0] rx_code;
  logic [`UFC_BYTES_W-1:0] tx_msg_bytes;
  logic [`UFC_BEATS_W-1:0] tx_msg_beats;
  logic [`KEEP_W-1:0] rx_keep;
  logic rx_is_last;
  ufc_word_t rx_word;

  // Ports show the code in the configured bit order; inside it is canonical
  function automatic logic [`CODE_W-1:0] order_code(
    input logic [`CODE_W-1:0] c
  );
    logic [`CODE_W-1:0] r;
    r = c;
    if (BIG_ENDIAN) begin
      for (int i = 0; i < `CODE_W; i++) begin
        r[i] = c[`CODE_W-1-i];
      end
    end
    return r;
  endfunction

  // Message length in bytes and in interface beats
  always_comb begin
    tx_msg_bytes = {1'b0, ufc_tx_tdata, 1'b0} + `UFC_BYTES_W'h2;
    tx_msg_beats = `UFC_BEATS_W'(
      (tx_msg_bytes + `UFC_BYTES_W'(`IF_BYTES - 1)) /
      `UFC_BYTES_W'(`IF_BYTES));
  end

  // Keep bits count from the most significant byte down
  genvar g;
  generate
    for (g = 0; g < `KEEP_W; g++) begin : keep_gen
      assign rx_keep[g] =
        (`UFC_BYTES_W'(`KEEP_W - 1 - g) < cur.rx_bytes_left);
    end
  endgenerate

  assign rx_is_last = (cur.rx_bytes_left <= `UFC_BYTES_W'(`IF_BYTES));
  assign rx_code = lane_rx.data[`CODE_W-1:0];

  always_comb begin
    rx_word.data = lane_rx.data;
    rx_word.last = rx_is_last;
    rx_word.keep = rx_is_last ? rx_keep : `KEEP_ALL;
  end

  // Transmit arbitration
  always_comb begin
    pause_pending = (cur.pause_left != '0) || cur.halt;
    // Completion mode waits for the frame boundary
    pause_go = (cur.tx_state == TX_DATA) && pause_pending &&
               (NFC_IMMEDIATE || !cur.in_frame);
    nfc_accept = (cur.tx_state == TX_DATA) && !pause_go && NFC_ON &&
                 nfc_tx_tvalid;
    ufc_accept = (cur.tx_state == TX_DATA) && !pause_go && !nfc_accept &&
                 ufc_tx_tvalid;
    tx_tready = (cur.tx_state == TX_DATA) && !pause_go &&
                !ufc_accept;
    data_accept = tx_tready && tx_tvalid;
    nfc_tx_tready = nfc_accept;
    ufc_tx_tready = ufc_accept;
  end

  // Receive side handshakes; the buffer's fill level stalls the lane
  always_comb begin
    lane_rx_ready = (cur.buf_count != `BUF_CNT_W'(`BUF_DEPTH));
    rx_take = lane_rx_valid && lane_rx_ready;
    ufc_rx_tvalid = (cur.buf_count != '0);
    rx_pop = ufc_rx_tvalid && ufc_rx_tready;
    ufc_rx_tdata = cur.buf_mem[cur.buf_rd].data;
    ufc_rx_tkeep = cur.buf_mem[cur.buf_rd].keep;
    ufc_rx_tlast = cur.buf_mem[cur.buf_rd].last;
    nfc_rx_tvalid = cur.nfc_rx_valid;
    nfc_rx_tdata = order_code(cur.nfc_rx_code);
    lane_tx = cur.lane;
  end

  always_comb begin
    next_cur = cur;
    next_cur.nfc_rx_valid = 1'b0;
    next_cur.lane.kind = KIND_IDLE;
    next_cur.lane.last = 1'b0;
    next_cur.lane.data = '0;

    // Frame tracking for completion mode
    if (data_accept) begin
      next_cur.in_frame = !tx_tlast;
    end

    case (cur.tx_state)
      TX_DATA: begin
        if (pause_go) begin
          // Idle beat now; the counted idles follow in the pause state
          next_cur.tx_state = TX_PAUSE;
        end else if (ufc_accept) begin
          // Header goes out in the acceptance cycle
          next_cur.lane.kind = KIND_UFC_HDR;
          next_cur.lane.data = `DATA_W'(ufc_tx_tdata);
          next_cur.ufc_beats_left = tx_msg_beats;
          next_cur.tx_state = TX_UFC;
        end else begin
          if (data_accept) begin
            next_cur.lane.kind = KIND_DATA;
            next_cur.lane.last = tx_tlast;
            next_cur.lane.data = tx_tdata;
          end
          if (nfc_accept) begin
            next_cur.nfc_send_code = order_code(nfc_tx_tdata);
            next_cur.tx_state = TX_NFC;
          end
        end
      end
      TX_UFC: begin
        // Payload sits on the regular data port; ready is held low
        next_cur.lane.kind = KIND_UFC_DATA;
        next_cur.lane.data = tx_tdata;
        next_cur.lane.last = (cur.ufc_beats_left == `UFC_BEATS_W'h1);
        next_cur.ufc_beats_left = cur.ufc_beats_left - `UFC_BEATS_W'h1;
        if (cur.ufc_beats_left <= `UFC_BEATS_W'h1) begin
          next_cur.tx_state = TX_DATA;
        end
      end
      TX_NFC: begin
        // Single gap beat carries the request, no user data
        next_cur.lane.kind = KIND_NFC;
        next_cur.lane.data = `DATA_W'(cur.nfc_send_code);
        next_cur.tx_state = TX_DATA;
      end
      TX_PAUSE: begin
        // Idles only; a halt keeps this state until a resume or a count code arrives
        if (cur.pause_left != '0) begin
          next_cur.pause_left = cur.pause_left - `PAUSE_W'h1;
        end
        if (!cur.halt && cur.pause_left <= `PAUSE_W'h1) begin
          next_cur.tx_state = TX_DATA;
        end
      end
      default: begin
        next_cur.tx_state = TX_DATA;
      end
    endcase

    // Partner idle requests; a later code replaces the running one
    if (rx_take && lane_rx.kind == KIND_NFC && NFC_ON) begin
      if (rx_code == `CODE_RESUME) begin
        next_cur.pause_left = '0;
        next_cur.halt = 1'b0;
        next_cur.nfc_rx_valid = 1'b1;
        next_cur.nfc_rx_code = rx_code;
      end else if (rx_code <= `CODE_MAX_COUNT) begin
        // Codes 1..8 map to 2^code idles
        next_cur.pause_left = `PAUSE_W'(1) << rx_code;
        next_cur.halt = 1'b0;
        next_cur.nfc_rx_valid = 1'b1;
        next_cur.nfc_rx_code = rx_code;
      end else if (rx_code == `CODE_HALT) begin
        next_cur.halt = 1'b1;
        next_cur.nfc_rx_valid = 1'b1;
        next_cur.nfc_rx_code = rx_code;
      end
      // Reserved codes are dropped without effect
    end

    // Received user messages: header sets the byte count
    if (rx_take && lane_rx.kind == KIND_UFC_HDR) begin
      next_cur.rx_bytes_left =
        {1'b0, lane_rx.data[`SIZE_W-1:0], 1'b0} + `UFC_BYTES_W'h2;
    end

    // Payload words go through the two-entry buffer
    if (rx_take && lane_rx.kind == KIND_UFC_DATA) begin
      next_cur.buf_mem[cur.buf_wr] = rx_word;
      next_cur.buf_wr = !cur.buf_wr;
      if (rx_is_last) begin
        next_cur.rx_bytes_left = '0;
      end else begin
        next_cur.rx_bytes_left =
          cur.rx_bytes_left - `UFC_BYTES_W'(`IF_BYTES);
      end
    end
    if (rx_pop) begin
      next_cur.buf_rd = !cur.buf_rd;
    end
    // Push and pop in one cycle leave the level unchanged
    case ({rx_take && lane_rx.kind == KIND_UFC_DATA, rx_pop})
      2'b10: next_cur.buf_count = cur.buf_count + `BUF_CNT_W'h1;
      2'b01: next_cur.buf_count = cur.buf_count - `BUF_CNT_W'h1;
      default: next_cur.buf_count = cur.buf_count;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cur <= '0;
      cur.tx_state <= TX_DATA;
      cur.lane.kind <= KIND_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

endmodule

/* tb/link_fc_chk.sv */
`timescale 1ns/1ns
module link_fc_chk
  import link_fc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Transmit side
  input wire logic [31:0] tx_tdata,
  input wire logic tx_tvalid,
  input wire logic tx_tready,
  input wire logic [2:0] ufc_tx_tdata,
  input wire logic ufc_tx_tready,
  input wire logic nfc_tx_tready,
  input wire lane_word_t lane_tx,
  // Receive side
  input wire logic [3:0] nfc_rx_tdata,
  input wire logic nfc_rx_tvalid,
  input wire logic [31:0] ufc_rx_tdata,
  input wire logic ufc_rx_tlast,
  input wire logic ufc_rx_tvalid,
  input wire logic ufc_rx_tready,
  input wire lane_word_t lane_rx,
  input wire logic lane_rx_valid,
  input wire logic lane_rx_ready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_nfc_gap: assert property (nfc_tx_tready |=> !tx_tready)
    else $error("tx ready high after idle request accept");
  chk_nfc_slot: assert property (
    nfc_tx_tready |-> ##2 lane_tx.kind == KIND_NFC)
    else $error("idle request word missing");
  chk_ufc_short: assert property (
    ufc_tx_tready && ufc_tx_tdata == 3'h1 |-> !tx_tready ##1 !tx_tready)
    else $error("short message gap wrong");
  chk_ufc_long: assert property (
    ufc_tx_tready && ufc_tx_tdata == 3'h3 |-> !tx_tready [*3])
    else $error("long message gap wrong");
  chk_code_echo: assert property (
    lane_rx_valid && lane_rx_ready && lane_rx.kind == KIND_NFC &&
    lane_rx.data[3:0] inside {[4'h1:4'h8]}
    |=> nfc_rx_tvalid && nfc_rx_tdata == $past(lane_rx.data[3:0]))
    else $error("received code not presented");
  chk_rsvd_drop: assert property (
    lane_rx_valid && lane_rx_ready && lane_rx.kind == KIND_NFC &&
    lane_rx.data[3:0] inside {[4'h9:4'hE]} |=> !nfc_rx_tvalid)
    else $error("reserved code presented");
  chk_rx_hold: assert property (ufc_rx_tvalid && !ufc_rx_tready
    |=> ufc_rx_tvalid && $stable(ufc_rx_tdata) && $stable(ufc_rx_tlast))
    else $error("stalled receive word changed");
  chk_empty_ready: assert property (
    !ufc_rx_tvalid |-> lane_rx_ready)
    else $error("empty buffer refuses lane words");
  chk_tx_word: assert property (tx_tvalid && tx_tready |=>
    lane_tx.kind == KIND_DATA && lane_tx.data == $past(tx_tdata))
    else $error("regular word not forwarded");
endmodule
bind link_flow_control_msg_port link_fc_chk link_fc_chk_inst (.*);

/* tb/ufc_sink.sv */
`timescale 1ns/1ns
module ufc_sink (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Stall control and handshake
  input wire logic slow,
  output logic ufc_rx_tready
);
  int seed = 35546;
  // Slow mode takes a word one cycle in four, so the buffer fills
  always @(negedge clk_sys) begin
    if (reset) ufc_rx_tready <= 1'b0;
    else ufc_rx_tready <= slow ? (($random(seed) & 3) == 0) : 1'b1;
  end
endmodule

/* tb/link_flow_control_msg_port_tb.sv */
`timescale 1ns/1ns
module link_flow_control_msg_port_tb;
  import link_fc_pkg::*;
  logic clk_sys, reset, tx_tvalid, tx_tlast, tx_tready, ufc_tx_tvalid;
  logic ufc_tx_tready, nfc_tx_tvalid, nfc_tx_tready, nfc_rx_tvalid, slow;
  logic ufc_rx_tlast, ufc_rx_tvalid, ufc_rx_tready, lane_rx_valid;
  logic lane_rx_ready;
  logic [31:0] tx_tdata, ufc_rx_tdata, d;
  logic [2:0] ufc_tx_tdata;
  logic [3:0] nfc_tx_tdata, nfc_rx_tdata, ufc_rx_tkeep, exp_code;
  lane_word_t lane_tx, lane_rx, w;
  lane_word_t lane_q[$];
  ufc_word_t rx_q[$];
  ufc_word_t u;
  int n_mismatch = 0, total_checks = 0, seed = 35546, k;
  int n_code = 0;
  link_flow_control_msg_port link_flow_control_msg_port_inst (.*);
  ufc_sink ufc_sink_inst (.*);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (e !== s) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task print_verdict;
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_ready(ref logic r);
    #1;
    while (!r) begin @(negedge clk_sys); #1; end
  endtask
  task send_data(input int n);
    for (int i = 0; i < n; i++) begin
      tx_tvalid = 1'b1;
      tx_tdata = $random(seed);
      tx_tlast = (i == n - 1);
      wait_ready(tx_tready);
      lane_q.push_back({KIND_DATA, tx_tlast, tx_tdata});
      @(negedge clk_sys);
    end
    tx_tvalid = 1'b0;
  endtask
  task ufc_send(input logic [2:0] sz);
    int low;
    ufc_tx_tvalid = 1'b1;
    ufc_tx_tdata = sz;
    wait_ready(ufc_tx_tready);
    lane_q.push_back({KIND_UFC_HDR, 1'b0, 29'h0, sz});
    low = 1;
    do begin
      @(negedge clk_sys);
      ufc_tx_tvalid = 1'b0;
      tx_tdata = $random(seed);
      #1;
      if (!tx_tready) begin
        low++;
        lane_q.push_back({KIND_UFC_DATA, 1'b0, tx_tdata});
      end
    end while (!tx_tready && low < 20);
    chk("ufc gap", 1 + (sz + 2) / 2, low);
  endtask
  task nfc_send(input logic [3:0] c);
    nfc_tx_tvalid = 1'b1;
    nfc_tx_tdata = c;
    wait_ready(nfc_tx_tready);
    lane_q.push_back({KIND_NFC, 1'b0, 28'h0, c});
    @(negedge clk_sys);
    nfc_tx_tvalid = 1'b0;
    #1;
    chk("tx ready after request", 0, tx_tready);
  endtask
  task lane_put(input beat_kind_t kd, input logic [31:0] dt);
    lane_rx = {kd, 1'b0, dt};
    lane_rx_valid = 1'b1;
    wait_ready(lane_rx_ready);
    @(negedge clk_sys);
  endtask
  task pause_rx(input logic [3:0] c, input int lo, input int hi);
    int n, t;
    exp_code = c;
    lane_put(KIND_NFC, {28'h0, c});
    lane_rx_valid = 1'b0;
    n = 0;
    t = 0;
    while (tx_tready && t < 4) begin @(negedge clk_sys); #1; t++; end
    while (!tx_tready && n <= hi) begin @(negedge clk_sys); #1; n++; end
    chk("idle span", 1, n >= lo && (n <= hi || c == 4'hF));
  endtask
  task rx_msg(input logic [2:0] sz);
    int rem;
    logic [31:0] dv;
    lane_put(KIND_UFC_HDR, {29'h0, sz});
    for (rem = 2 * (sz + 1); rem > 0; rem -= 4) begin
      dv = $random(seed);
      lane_put(KIND_UFC_DATA, dv);
      rx_q.push_back({rem <= 4, rem >= 4 ? 4'hF : 4'hC, dv});
    end
    lane_rx_valid = 1'b0;
    @(negedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    if (!reset && lane_tx.kind != KIND_IDLE) begin
      w = lane_q.pop_front();
      d = lane_tx.data;
      if (w.kind == KIND_NFC) d = {28'h0, d[3:0]};
      if (w.kind == KIND_UFC_HDR) d = {29'h0, d[2:0]};
      chk("lane kind", 32'(w.kind), 32'(lane_tx.kind));
      chk("lane data", w.data, d);
    end
    if (!reset && nfc_rx_tvalid) begin
      n_code++;
      chk("rx code", 32'(exp_code), 32'(nfc_rx_tdata));
    end
    if (!reset && ufc_rx_tvalid && ufc_rx_tready) begin
      u = rx_q.pop_front();
      chk("rx data", u.data, ufc_rx_tdata);
      chk("rx last", 32'(u.last), 32'(ufc_rx_tlast));
      if (u.last) chk("rx keep", 32'(u.keep), 32'(ufc_rx_tkeep));
    end
  end
  initial begin
    #200000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    {reset, slow} = 2'b10;
    {tx_tvalid, tx_tlast, ufc_tx_tvalid, nfc_tx_tvalid} = 4'h0;
    {tx_tdata, ufc_tx_tdata, nfc_tx_tdata} = '0;
    lane_rx = '0;
    lane_rx_valid = 1'b0;
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    send_data(6);
    for (k = 0; k < 8; k++) ufc_send(k[2:0]);
    for (k = 0; k < 10; k++) nfc_send(k == 9 ? 4'hF : k[3:0]);
    send_data(3);
    // Partner request lands in the middle of a frame
    fork
      send_data(6);
      begin
        repeat (2) @(negedge clk_sys);
        pause_rx(4'h2, 4, 12);
      end
    join
    for (k = 1; k < 9; k++) begin
      pause_rx(k[3:0], 1 << k, (1 << k) + 8);
    end
    pause_rx(4'h9, 0, 0);
    pause_rx(4'hF, 61, 60);
    pause_rx(4'h0, 0, 8);
    slow = 1'b1;
    for (k = 0; k < 8; k++) rx_msg(k[2:0]);
    slow = 1'b0;
    repeat (20) @(negedge clk_sys);
    chk("lane queue", 0, lane_q.size());
    chk("rx queue", 0, rx_q.size());
    chk("rx code count", 11, n_code);
    print_verdict;
  end
endmodule
